/* File: shared/cdm_defs.svh */
// named constants of the clock manager: widths, limits, defaults and counts
`ifndef CDM_DEFS_SVH
`define CDM_DEFS_SVH

// width of period, phase and edge counters
`define CDM_PER_W 12
// width of the synthesis accumulators (divide value times period)
`define CDM_DP_W 18
// counter value that means no input edge was seen for too long
`define CDM_STOP_CYC 12'hffe
// shortest input period, in system cycles, that can be tracked
`define CDM_PER_MIN 12'h008
// consecutive matching feedback edges needed before lock
`define CDM_LOCK_MATCH 3'h4
// fine phase limits, in 1/256 of the input period
`define CDM_PS_MAX 9'h0ff
`define CDM_PS_MIN 9'h101
// fraction shift of the fine phase value
`define CDM_FRAC_SH 8
// synthesis defaults, used when the ratio field is zero
`define CDM_FX_M_DEF 5'h04
`define CDM_FX_D_DEF 5'h01
// divide value in half steps: 1.5 is the least, above 8 only whole steps
`define CDM_DV_MIN 6'h03
`define CDM_DV_HALF_TOP 6'h10
// numerator of the doubled and divided tones
`define CDM_DOUBLE_NUM 5'h02
// number of pins passed through the synchroniser
`define CDM_PIN_N 5

`endif

/* File: shared/cdm_pkg.sv */
// types shared by the clock manager modules
package cdm_pkg;

  // lock sequence, gray coded along idle, measure, tune, locked
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_measure = 2'b01,
    st_tune = 2'b11,
    st_locked = 2'b10
  } cdm_state_t;

  // result of comparing feedback edge against the phase target
  typedef enum logic [1:0] {
    skew_match = 2'b00,
    skew_late = 2'b01,
    skew_early = 2'b10
  } cdm_skew_t;

  // static configuration inputs
  typedef struct packed {
    logic hf_mode;
    logic fb_used;
    logic variable_mode;
    logic startup_wait;
    logic [5:0] div_half;
    logic [4:0] fx_m;
    logic [4:0] fx_d;
    logic signed [8:0] phase_cfg;
  } cdm_cfg_t;

  // status byte, bit 0 is the last field
  typedef struct packed {
    logic [4:0] unused;
    logic fx_stopped;
    logic in_stopped;
    logic ps_overflow;
  } cdm_status_t;

  // the nine generated clocks
  typedef struct packed {
    logic zero;
    logic quarter;
    logic half;
    logic three_q;
    logic doubled;
    logic doubled_inv;
    logic divided;
    logic synth;
    logic synth_inv;
  } cdm_clk_t;

  // pins that arrive from outside the system clock domain
  typedef struct packed {
    logic in_clk;
    logic fb;
    logic ps_clk;
    logic ps_en;
    logic ps_dir;
  } cdm_pins_t;

endpackage : cdm_pkg

/* File: src/cdm_pin_sync.sv */
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`include "cdm_defs.svh"
module cdm_pin_sync (
  // clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // raw pins and their filtered views
  input wire cdm_pkg::cdm_pins_t pins,
  output cdm_pkg::cdm_pins_t level,
  output cdm_pkg::cdm_pins_t rise
);
  logic [`CDM_PIN_N-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, nxt_lvl;

  // a level only moves once stages two and three agree
  assign nxt_lvl = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & lvl_ff);

  // first stage is read only by the second
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else if (clk_en) begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // filtered level and one-cycle rise pulse
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lvl_ff <= '0;
      rise_ff <= '0;
    end else if (clk_en) begin
      lvl_ff <= nxt_lvl;
      rise_ff <= nxt_lvl & ~lvl_ff;
    end
  end

  assign level = lvl_ff;
  assign rise = rise_ff;
endmodule : cdm_pin_sync

/* File: src/cdm_tone_gen.sv */
// ratio tone generator: 50/50 square wave at num/den_p of the system clock
`timescale 1ns/1ps
`include "cdm_defs.svh"
module cdm_tone_gen (
  // clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // control
  input wire logic run,
  input wire logic align,
  input wire logic [4:0] num,
  input wire logic [`CDM_DP_W-1:0] den_p,
  // tone
  output logic tone
);
  localparam int DW = `CDM_DP_W;
  logic [DW-1:0] acc_ff;
  logic tone_ff;
  logic [DW:0] sum;

  // two toggles per output period, so the step is twice the numerator
  assign sum = {1'b0, acc_ff} + (DW+1)'({num, 1'b0});

  // align restarts the wave on a rising edge so tones stay phase locked
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc_ff <= '0;
      tone_ff <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        acc_ff <= '0;
        tone_ff <= 1'b0;
      end else if (align) begin
        acc_ff <= '0;
        tone_ff <= 1'b1;
      end else if (sum >= {1'b0, den_p}) begin
        acc_ff <= DW'(sum - {1'b0, den_p});
        tone_ff <= ~tone_ff;
      end else begin
        acc_ff <= sum[DW-1:0];
      end
    end
  end

  assign tone = tone_ff;
endmodule : cdm_tone_gen

/* File: src/cdm_clock_manager.sv */
// clock manager top: de-skew loop, clock synthesis, phase stepping, lock and status
// What this block does
// - optionally hold configuration release low until lock is reached
// - reset input returns every part of the manager to its initial state
// - lock goes high only when every enabled circuit has locked
// - eight-bit status: overflow, input stopped, synthesised stopped, rest zero
// - a tuned delay tap aligns generated edges with the input edge
// - all outputs are aligned to the zero-phase output and the input
// - doubled output and its inverse run at twice the input rate
// - divide 1.5 to 8 in half steps, 9 to 31 whole steps
// - synthesised rate is input times M over D, default four over one
// - inverted synthesised and inverted doubled outputs sit 180 degrees away
// - synthesis outputs have 50/50 duty
// - high-frequency mode switches off the doubled outputs
// - coarse outputs at 0, 90, 180, 270 degrees of the input period
// - high-frequency mode switches off the 90 and 270 degree outputs
// - fine phase shifts all nine outputs by a fraction of the period when feedback is used
// - variable mode steps the phase up or down on enabled step edges
`timescale 1ns/1ps
`include "cdm_defs.svh"
module cdm_clock_manager (
  // system clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // pins from outside the system clock domain
  input wire logic input_clock,
  input wire logic feedback_clock,
  input wire logic phase_step_clock,
  input wire logic phase_step_enable,
  input wire logic phase_step_direction,
  // static configuration
  input wire cdm_pkg::cdm_cfg_t cfg,
  // generated clocks
  output cdm_pkg::cdm_clk_t clks,
  // lock, status and configuration hold-off
  output logic locked,
  output cdm_pkg::cdm_status_t status,
  output logic config_release
);
  localparam int PW = `CDM_PER_W;
  localparam int DW = `CDM_DP_W;

  cdm_pkg::cdm_pins_t pin_raw, pin_lvl, pin_rise;
  cdm_pkg::cdm_state_t st_ff, nxt_st;
  cdm_pkg::cdm_skew_t skew;
  logic [PW-1:0] q_in_ff, per_ff, tap_ff, q_loc_ff, fx_cnt_ff, dv_cnt_ff;
  logic [PW-1:0] per_meas, tgt_mod, per_half, per_qtr, fb_off;
  logic signed [8:0] ps_val_ff;
  logic ps_ovf_ff;
  logic [2:0] match_ff;
  logic [DW-1:0] fx_idle_ff, den_x2, den_dv, den_fx;
  logic signed [21:0] tgt_raw, tgt_sh;
  logic [4:0] m_eff, d_eff;
  logic [5:0] dv_eff;
  logic in_stop_c, per_same, gen_run, loc_edge, step_c, step_over, fx_stop_c, lock_c;
  logic x2_tone, dv_tone, fx_tone;
  cdm_pkg::cdm_clk_t clks_ff;
  cdm_pkg::cdm_status_t status_ff;
  logic locked_ff, release_ff;

  // wrapping counter step used by the tap and the edge counters
  function automatic logic [PW-1:0] cdm_wrap_inc(input logic [PW-1:0] v,
                                                 input logic [PW-1:0] top);
    cdm_wrap_inc = (v >= top) ? '0 : PW'(v + 1'b1);
  endfunction : cdm_wrap_inc

  function automatic logic [PW-1:0] cdm_wrap_dec(input logic [PW-1:0] v,
                                                 input logic [PW-1:0] top);
    cdm_wrap_dec = (v == '0) ? top : PW'(v - 1'b1);
  endfunction : cdm_wrap_dec

  // distance from target to feedback edge, modulo the period
  function automatic cdm_pkg::cdm_skew_t cdm_skew_dir(input logic [PW-1:0] off,
                                                      input logic [PW-1:0] tgt,
                                                      input logic [PW-1:0] per);
    logic [PW-1:0] d;
    d = (off >= tgt) ? PW'(off - tgt) : PW'(off + per - tgt);
    if (off == tgt) begin
      cdm_skew_dir = cdm_pkg::skew_match;
    end else if (d <= (per >> 1)) begin
      cdm_skew_dir = cdm_pkg::skew_late;
    end else begin
      cdm_skew_dir = cdm_pkg::skew_early;
    end
  endfunction : cdm_skew_dir

  // every pin is from another domain, so all pass the synchroniser
  assign pin_raw = '{in_clk: input_clock, fb: feedback_clock, ps_clk: phase_step_clock,
                     ps_en: phase_step_enable, ps_dir: phase_step_direction};

  cdm_pin_sync u_sync (
    .clock(clock),
    .nrst(nrst),
    .clk_en(clk_en),
    .pins(pin_raw),
    .level(pin_lvl),
    .rise(pin_rise)
  );

  // period measurement and input-stopped detection
  assign in_stop_c = (q_in_ff == `CDM_STOP_CYC);
  assign per_meas = PW'(q_in_ff + 1'b1);
  assign per_same = (per_meas == per_ff) && (per_meas >= `CDM_PER_MIN);
  assign per_half = per_ff >> 1;
  assign per_qtr = per_ff >> 2;

  // cycles since the last input rise, saturating at the stop mark
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q_in_ff <= '0;
    end else if (clk_en) begin
      if (pin_rise.in_clk) begin
        q_in_ff <= '0;
      end else if (!in_stop_c) begin
        q_in_ff <= PW'(q_in_ff + 1'b1);
      end
    end
  end

  // last measured period
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      per_ff <= '0;
    end else if (clk_en && pin_rise.in_clk) begin
      per_ff <= per_meas;
    end
  end

  // synthesis ratios; zero fields select the defaults
  assign m_eff = (cfg.fx_m == '0) ? `CDM_FX_M_DEF : cfg.fx_m;
  assign d_eff = (cfg.fx_d == '0) ? `CDM_FX_D_DEF : cfg.fx_d;
  // below 1.5 clamps up, above 8 drops to the whole step below
  always_comb begin
    if (cfg.div_half < `CDM_DV_MIN) begin
      dv_eff = `CDM_DV_MIN;
    end else if (cfg.div_half > `CDM_DV_HALF_TOP) begin
      dv_eff = {cfg.div_half[5:1], 1'b0};
    end else begin
      dv_eff = cfg.div_half;
    end
  end

  assign den_x2 = DW'(per_ff);
  assign den_dv = DW'(dv_eff) * DW'(per_ff);
  assign den_fx = DW'(d_eff) * DW'(per_ff);

  // fine phase step; out-of-range steps are dropped and flagged
  // steps wait for idle to end, since idle is where the start value is loaded
  assign step_c = pin_rise.ps_clk && pin_lvl.ps_en && cfg.variable_mode
                  && (st_ff != cdm_pkg::st_idle);
  assign step_over = step_c && (pin_lvl.ps_dir ? (ps_val_ff == `CDM_PS_MAX)
                                               : (ps_val_ff == `CDM_PS_MIN));

  // fixed mode follows the configured value, variable mode loads it while idle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ps_val_ff <= '0;
    end else if (clk_en) begin
      if (!cfg.variable_mode || (st_ff == cdm_pkg::st_idle)) begin
        ps_val_ff <= cfg.phase_cfg;
      end else if (step_c && !step_over) begin
        ps_val_ff <= pin_lvl.ps_dir ? ps_val_ff + 9'sh001 : ps_val_ff - 9'sh001;
      end
    end
  end

  // overflow holds until the next accepted step
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ps_ovf_ff <= 1'b0;
    end else if (clk_en) begin
      if (step_over) begin
        ps_ovf_ff <= 1'b1;
      end else if (step_c || !cfg.variable_mode) begin
        ps_ovf_ff <= 1'b0;
      end
    end
  end

  // phase target: fraction of the period, folded into 0..period-1
  assign tgt_raw = ps_val_ff * $signed({1'b0, per_ff});
  assign tgt_sh = tgt_raw >>> `CDM_FRAC_SH;
  assign tgt_mod = tgt_sh[21] ? PW'(tgt_sh + $signed({1'b0, per_ff})) : tgt_sh[PW-1:0];
  // count this edge too, so a feedback rise on the input's own edge reads as zero skew
  assign fb_off = pin_rise.in_clk ? '0 : per_meas;
  assign skew = cdm_skew_dir(fb_off, tgt_mod, per_ff);

  // delay tap: one step per feedback edge, late edges pull it back
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tap_ff <= '0;
    end else if (clk_en) begin
      if (!cfg.fb_used || tap_ff >= per_ff) begin
        tap_ff <= '0;
      end else if (pin_rise.fb && gen_run) begin
        if (skew == cdm_pkg::skew_late) begin
          tap_ff <= cdm_wrap_dec(tap_ff, PW'(per_ff - 1'b1));
        end else if (skew == cdm_pkg::skew_early) begin
          tap_ff <= cdm_wrap_inc(tap_ff, PW'(per_ff - 1'b1));
        end
      end
    end
  end

  // consecutive matching feedback edges while tuning
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      match_ff <= '0;
    end else if (clk_en) begin
      if (st_ff != cdm_pkg::st_tune) begin
        match_ff <= '0;
      end else if (pin_rise.fb) begin
        match_ff <= (skew == cdm_pkg::skew_match) ? 3'(match_ff + 1'b1) : '0;
      end
    end
  end

  // lock sequence; a stopped input or a period change restarts it
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      cdm_pkg::st_idle: begin
        if (pin_rise.in_clk) begin
          nxt_st = cdm_pkg::st_measure;
        end
      end
      cdm_pkg::st_measure: begin
        if (pin_rise.in_clk && per_same) begin
          nxt_st = cfg.fb_used ? cdm_pkg::st_tune : cdm_pkg::st_locked;
        end
      end
      cdm_pkg::st_tune: begin
        if (in_stop_c || (pin_rise.in_clk && !per_same)) begin
          nxt_st = cdm_pkg::st_measure;
        end else if (match_ff == `CDM_LOCK_MATCH) begin
          nxt_st = cdm_pkg::st_locked;
        end
      end
      default: begin
        if (in_stop_c || (pin_rise.in_clk && !per_same)) begin
          nxt_st = cdm_pkg::st_measure;
        end
      end
    endcase
  end

  // reset returns the sequence to idle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= cdm_pkg::st_idle;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // local reference edge sits tap cycles after the input edge
  assign gen_run = (st_ff == cdm_pkg::st_tune) || (st_ff == cdm_pkg::st_locked);
  assign loc_edge = gen_run && !in_stop_c && (q_in_ff == tap_ff);

  // phase within the local period, drives the coarse outputs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q_loc_ff <= '0;
    end else if (clk_en) begin
      if (loc_edge) begin
        q_loc_ff <= '0;
      end else if (q_loc_ff != `CDM_STOP_CYC) begin
        q_loc_ff <= PW'(q_loc_ff + 1'b1);
      end
    end
  end

  // divided and synthesised waves realign only every D or dv_eff (twice the divide) edges
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fx_cnt_ff <= '0;
      dv_cnt_ff <= '0;
    end else if (clk_en) begin
      if (!gen_run) begin
        fx_cnt_ff <= '0;
        dv_cnt_ff <= '0;
      end else if (loc_edge) begin
        fx_cnt_ff <= cdm_wrap_inc(fx_cnt_ff, PW'(d_eff - 1'b1));
        dv_cnt_ff <= cdm_wrap_inc(dv_cnt_ff, PW'(dv_eff - 1'b1));
      end
    end
  end

  // tones must stay below half the system clock rate to keep their shape
  cdm_tone_gen u_x2 (
    .clock(clock),
    .nrst(nrst),
    .clk_en(clk_en),
    .run(gen_run && !cfg.hf_mode),
    .align(loc_edge),
    .num(`CDM_DOUBLE_NUM),
    .den_p(den_x2),
    .tone(x2_tone)
  );

  cdm_tone_gen u_dv (
    .clock(clock),
    .nrst(nrst),
    .clk_en(clk_en),
    .run(gen_run),
    .align(loc_edge && (dv_cnt_ff == '0)),
    .num(`CDM_DOUBLE_NUM),
    .den_p(den_dv),
    .tone(dv_tone)
  );

  cdm_tone_gen u_fx (
    .clock(clock),
    .nrst(nrst),
    .clk_en(clk_en),
    .run(gen_run),
    .align(loc_edge && (fx_cnt_ff == '0)),
    .num(m_eff),
    .den_p(den_fx),
    .tone(fx_tone)
  );

  // synthesised-stopped: no toggle for D input periods (M synthesised periods)
  assign fx_stop_c = gen_run && (fx_idle_ff > den_fx);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fx_idle_ff <= '0;
    end else if (clk_en) begin
      if (!gen_run || (fx_tone != clks_ff.synth)) begin
        fx_idle_ff <= '0;
      end else if (!fx_stop_c) begin
        fx_idle_ff <= DW'(fx_idle_ff + 1'b1);
      end
    end
  end

  // output clocks; each inverse is the complement of the same tone
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clks_ff <= '0;
    end else if (clk_en) begin
      clks_ff.zero <= gen_run && (q_loc_ff < per_half);
      clks_ff.half <= gen_run && !(q_loc_ff < per_half);
      clks_ff.quarter <= gen_run && !cfg.hf_mode && (q_loc_ff >= per_qtr)
                         && (q_loc_ff < PW'(per_qtr + per_half));
      clks_ff.three_q <= gen_run && !cfg.hf_mode && !((q_loc_ff >= per_qtr)
                         && (q_loc_ff < PW'(per_qtr + per_half)));
      clks_ff.doubled <= gen_run && !cfg.hf_mode && x2_tone;
      clks_ff.doubled_inv <= gen_run && !cfg.hf_mode && !x2_tone;
      clks_ff.divided <= gen_run && dv_tone;
      clks_ff.synth <= gen_run && fx_tone;
      clks_ff.synth_inv <= gen_run && !fx_tone;
    end
  end

  // lock needs the sequence done, the input running and synthesis alive
  assign lock_c = (st_ff == cdm_pkg::st_locked) && !in_stop_c && !fx_stop_c;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      locked_ff <= 1'b0;
      release_ff <= 1'b0;
    end else if (clk_en) begin
      locked_ff <= lock_c;
      release_ff <= !cfg.startup_wait || lock_c;
    end
  end

  // status byte, spare bits always zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status_ff <= '0;
    end else if (clk_en) begin
      status_ff.unused <= '0;
      status_ff.ps_overflow <= ps_ovf_ff;
      status_ff.in_stopped <= in_stop_c;
      status_ff.fx_stopped <= fx_stop_c;
    end
  end

  assign clks = clks_ff;
  assign locked = locked_ff;
  assign status = status_ff;
  assign config_release = release_ff;

  // checks, sampled only on enabled cycles
  default clocking cb @(posedge clock iff clk_en);
  endclocking
  default disable iff (!nrst);

  sequence s_step_up;
    step_c && pin_lvl.ps_dir && (ps_val_ff != `CDM_PS_MAX);
  endsequence

  sequence s_step_down;
    step_c && !pin_lvl.ps_dir && (ps_val_ff != `CDM_PS_MIN);
  endsequence

  sequence s_step_beyond;
    step_c && pin_lvl.ps_dir && (ps_val_ff == `CDM_PS_MAX) ##1 cfg.variable_mode;
  endsequence

  property p_step_up;
    s_step_up |=> (ps_val_ff == $past(ps_val_ff) + 9'sh001);
  endproperty
  a_step_up: assert property (p_step_up) else $error("phase step up not applied");

  property p_step_down;
    s_step_down |=> (ps_val_ff == $past(ps_val_ff) - 9'sh001);
  endproperty
  a_step_down: assert property (p_step_down) else $error("phase step down not applied");

  property p_overflow;
    s_step_beyond |-> $stable(ps_val_ff) ##1 status_ff.ps_overflow;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow step not refused");

  property p_lock_cause;
    locked_ff |-> ($past(st_ff) == cdm_pkg::st_locked) && !$past(in_stop_c);
  endproperty
  a_lock_cause: assert property (p_lock_cause) else $error("lock without locked state");

  property p_stop_unlocks;
    status_ff.in_stopped |-> !locked_ff;
  endproperty
  a_stop_unlocks: assert property (p_stop_unlocks) else $error("locked with input stopped");

  property p_hold_config;
    (config_release && $past(cfg.startup_wait)) |-> locked_ff;
  endproperty
  a_hold_config: assert property (p_hold_config) else $error("release before lock");

  property p_status_spare;
    status_ff.unused == '0;
  endproperty
  a_status_spare: assert property (p_status_spare) else $error("spare status bits set");

  property p_hf_no_double;
    $past(cfg.hf_mode) |-> !clks_ff.doubled && !clks_ff.doubled_inv;
  endproperty
  a_hf_no_double: assert property (p_hf_no_double) else $error("doubled out in hf mode");

  property p_hf_no_quarter;
    $past(cfg.hf_mode) |-> !clks_ff.quarter && !clks_ff.three_q;
  endproperty
  a_hf_no_quarter: assert property (p_hf_no_quarter) else $error("quarter out in hf mode");

  property p_fx_anti;
    $past(gen_run) |-> (clks_ff.synth_inv != clks_ff.synth);
  endproperty
  a_fx_anti: assert property (p_fx_anti) else $error("synth inverse not opposite");

  property p_coarse_half;
    $past(gen_run) |-> (clks_ff.half != clks_ff.zero);
  endproperty
  a_coarse_half: assert property (p_coarse_half) else $error("half phase not opposite");
endmodule : cdm_clock_manager

/* File: bench/cdm_fabric_model.sv */
// user fabric model: feedback wiring and phase step strobes
`timescale 1ns/1ps
module cdm_fabric_model (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // zero-phase clock and bench step requests
  input wire logic zero_in,
  input wire logic go,
  input wire logic up,
  // pins towards the manager
  output logic fb,
  output logic ps_clk,
  output logic ps_en,
  output logic ps_dir
);
  logic [3:0] cnt_ff;
  // feedback taken straight from the zero-phase output
  assign fb = zero_in;
  // slow step clock; enable and direction stay steady well around each rise
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) cnt_ff <= 4'h0;
    else cnt_ff <= go ? cnt_ff + 4'h1 : 4'h0;
  end
  assign ps_clk = cnt_ff[3];
  assign ps_en = go;
  assign ps_dir = up;
endmodule : cdm_fabric_model

/* File: bench/tb_top.sv */
// self-checking bench of the clock manager
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic in_clk = 1'b0;
  logic run = 1'b0;
  logic go = 1'b0;
  logic up = 1'b1;
  logic [2:0] ph = 3'h0;
  logic fb, ps_clk, ps_en, ps_dir, locked, config_release;
  cdm_pkg::cdm_cfg_t cfg = '0;
  cdm_pkg::cdm_clk_t clks;
  cdm_pkg::cdm_status_t status;
  int fails = 0;
  int n_checks = 0;
  always #10 clock = ~clock;
  // input clock of 16 system cycles, stopped while run is low
  always @(posedge clock) begin
    ph <= ph + 3'h1;
    if (ph == 3'h7) in_clk <= run & ~in_clk;
  end
  cdm_clock_manager i_cdm_clock_manager (.clock(clock), .nrst(nrst), .clk_en(1'b1),
    .input_clock(in_clk), .feedback_clock(fb), .phase_step_clock(ps_clk),
    .phase_step_enable(ps_en), .phase_step_direction(ps_dir), .cfg(cfg), .clks(clks),
    .locked(locked), .status(status), .config_release(config_release));
  cdm_fabric_model i_cdm_fabric_model (.clock(clock), .nrst(nrst), .zero_in(clks.zero),
    .go(go), .up(up), .fb(fb), .ps_clk(ps_clk), .ps_en(ps_en), .ps_dir(ps_dir));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // reset with a new static setting, then wait a bounded time for lock
  task automatic start(input cdm_pkg::cdm_cfg_t c);
    int i;
    @(posedge clock);
    nrst <= 1'b0;
    run <= 1'b0;
    cfg <= c;
    repeat (4) @(posedge clock);
    chk({locked, config_release, 5'h0, clks}, 16'h0);
    chk(16'(status), 16'h0);
    nrst <= 1'b1;
    run <= 1'b1;
    repeat (3) @(posedge clock);
    chk({locked, config_release}, {1'b0, ~c.startup_wait});
    for (i = 0; i < 3000 && locked !== 1'b1; i++) @(negedge clock);
    chk({locked, config_release, status}, 16'h300);
  endtask : start
  // count rising edges over w cycles and check the synth and zero/half inverse pairs every cycle
  // off: cycles from an input rise to the zero-phase rise when feedback is closed
  task automatic rates(input int w, off, input logic [15:0] ez, eq, ed, ev, ef);
    logic [15:0] n [5];
    cdm_pkg::cdm_clk_t p;
    logic bad, pin;
    int na, since;
    n = '{default: 16'h0};
    bad = 1'b0;
    na = 0;
    since = 0;
    // start on an input rise so every window edge pair falls inside
    @(posedge in_clk);
    @(negedge clock);
    p = clks;
    pin = in_clk;
    repeat (w) begin
      @(negedge clock);
      since = (in_clk & ~pin) ? 0 : since + 1;
      na += int'(clks.zero & ~p.zero & (since == off));
      pin = in_clk;
      n[0] += 16'(clks.zero & ~p.zero);
      n[1] += 16'(clks.quarter & ~p.quarter);
      n[2] += 16'(clks.doubled & ~p.doubled);
      n[3] += 16'(clks.divided & ~p.divided);
      n[4] += 16'(clks.synth & ~p.synth);
      bad |= (clks.synth_inv !== ~clks.synth) | (clks.half !== ~clks.zero);
      p = clks;
    end
    chk(n[0], ez);
    chk(n[1], eq);
    chk(n[2], ed);
    chk(n[3], ev);
    chk(n[4], ef);
    chk(16'(bad), 16'h0);
    if (cfg.fb_used) chk(16'(na), ez);
  endtask : rates
  task automatic step(input logic dir, input logic [15:0] ovf);
    @(posedge clock);
    up <= dir;
    go <= 1'b1;
    repeat (16) @(posedge clock);
    go <= 1'b0;
    repeat (12) @(posedge clock);
    chk(16'(status.ps_overflow), ovf);
  endtask : step
  initial begin
    #(20 * 40000);
    fails++;
    tally_and_finish();
  end
  initial begin
    // default ratio, feedback loop closed, configuration held off
    start({4'b0101, 6'h03, 5'h0, 5'h0, 9'h0});
    rates(480, 0, 16'd30, 16'd30, 16'd60, 16'd20, 16'd120);
    $display("test defaults done");
    // a quarter-period fine phase puts the feedback edge four cycles late
    start({4'b0100, 6'h03, 5'h0, 5'h0, 9'h040});
    rates(480, 4, 16'd30, 16'd30, 16'd60, 16'd20, 16'd120);
    $display("test phase done");
    // high-frequency mode drops doubled and quarter outputs
    start({4'b1000, 6'h20, 5'h2, 5'h1, 9'h0});
    rates(768, 0, 16'd48, 16'd0, 16'd0, 16'd3, 16'd96);
    $display("test hf done");
    // phase stepping at the top of the range
    start({4'b0010, 6'h04, 5'h0, 5'h0, 9'h0ff});
    step(1'b1, 16'h1);
    step(1'b0, 16'h0);
    $display("test step done");
    // input clock stops
    run <= 1'b0;
    repeat (4200) @(posedge clock);
    chk({locked, 7'h0, status}, 16'h0002);
    $display("test stop done");
    tally_and_finish();
  end
endmodule : tb_top
